// *** rnirr_node.sv ***
// Ring node: interrupt packets, redundant copies, rogue removal
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module rnirr_node import rnirr_pkg::*; (
    // Clock and reset
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    // APB slave
    input  wire  logic [11:0] paddr,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    // Board pins
    input  wire  logic [7:0]  option_switch_bank,
    input  wire  logic [7:0]  node_id_switch,
    input  wire  logic        signal_detect,
    input  wire  logic        rx_locked,
    // Receive stream from upstream node
    input  wire  logic        rx_valid,
    input  wire  logic        rx_sop,
    input  wire  logic        rx_eop,
    input  wire  logic [31:0] rx_data,
    input  wire  logic        rx_err,
    output logic              rx_ready,
    // Transmit stream to downstream node
    output logic              tx_valid,
    output logic              tx_sop,
    output logic              tx_eop,
    output logic       [31:0] tx_data,
    input  wire  logic        tx_ready,
    // Local memory write port
    output logic              mem_we,
    output logic       [31:0] mem_addr,
    output logic       [31:0] mem_data,
    // Host interrupt
    output logic              host_irq
);

    function automatic logic [4:0] exp_len(input logic [31:0] hdr);
        if (hdr[HDR_KIND_BIT]) begin
            return IRQ_PKT_WORDS;
        end
        return 5'(hdr[HDR_LEN_LSB +: 4]) + DATA_PKT_EXTRA;
    endfunction

    function automatic logic fifo_addr(input logic [11:0] a, input int t,
                                       input logic data_word);
        logic [11:0] base;
        base = REG_FIFO_BASE + 12'(t) * REG_FIFO_STRIDE;
        return a == (data_word ? base + REG_FIFO_DATA : base);
    endfunction

    // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] pins_raw;

    assign pins_raw = {rx_locked, signal_detect, node_id_switch,
                       option_switch_bank};

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                    pins[g]  <= 1'b0;
                end else begin
                    sync1[g] <= pins_raw[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                    if (sync2[g] == sync3[g]) begin
                        pins[g] <= sync3[g];
                    end
                end
            end
        end
    endgenerate

    logic [7:0] opts;
    logic [7:0] my_id;
    logic       link_ok;
    logic       red_mode;
    logic       role0;
    logic       role1;

    assign opts     = pins[7:0];
    assign my_id    = pins[15:8];
    assign link_ok  = pins[16] & pins[17];
    assign red_mode = opts[OPT_REDUNDANT];
    assign role0    = opts[OPT_ROGUE0];
    assign role1    = opts[OPT_ROGUE1];

    // Software registers
    logic [8:0]      irq_target;
    logic [2:0]      irq_type;
    logic [31:0]     irq_data;
    logic            send_pending;
    logic [ST_W-1:0] local_irq_status;
    logic [ST_W-1:0] local_irq_enable;
    logic            host_irq_ctrl_status;

    // Packet path state
    rnirr_state_t state;
    rnirr_state_t next_state;
    logic [31:0]  pkt_buf [PKT_MAX];
    logic [4:0]   rx_cnt;
    logic         rx_bad;
    logic [4:0]   pkt_len;
    logic         fwd;
    logic         apply_mem;
    logic         second_copy;
    logic         first_ok;
    logic [4:0]   tx_idx;
    logic [1:0]   tx_pass;
    logic [4:0]   wr_idx;
    logic         tx_busy;
    logic         wr_busy;
    logic         rx_fire;
    logic         local_load;

    // Decision terms, valid in ST_DECIDE
    logic [31:0]         hdr_in;
    logic [31:0]         hdr_out;
    logic                take;
    logic                own;
    logic                rogue;
    logic                pass_on;
    logic                irq_hit;
    logic [GP_KINDS-1:0] ev_push;
    logic                ev_reset;
    logic                ev_rogue;
    logic                ev_own;

    // APB strobes
    logic        apb_cap;
    logic        apb_wr;
    logic        apb_rd_cap;
    logic [31:0] rd_word;
    logic        mapped;

    assign apb_cap    = psel & penable & ~pready;
    assign apb_wr     = psel & penable & pready & pwrite;
    assign apb_rd_cap = apb_cap & ~pwrite;
    assign rx_fire    = rx_valid & rx_ready;
    assign local_load = state == ST_IDLE && send_pending && !rx_valid
                        && link_ok;

    // Decision on a collected copy
    always_comb begin
        logic bad;
        logic foreign;
        bad     = 1'b0;
        foreign = 1'b0;
        hdr_in  = pkt_buf[0];
        bad     = rx_bad || rx_cnt != exp_len(hdr_in);
        if (!red_mode) begin
            take = !bad;
        end else if (!second_copy) begin
            take = !bad;
        end else begin
            take = !first_ok && !bad;
        end
        foreign = hdr_in[HDR_ORG_LSB +: 8] != my_id;
        own     = !foreign;
        rogue   = foreign && ((role0 && hdr_in[HDR_MARK0_BIT])
                  || (role1 && hdr_in[HDR_MARK1_BIT]));
        pass_on = take && !own && !rogue;
        hdr_out = hdr_in;
        hdr_out[HDR_MARK0_BIT] = hdr_in[HDR_MARK0_BIT] | role0;
        hdr_out[HDR_MARK1_BIT] = hdr_in[HDR_MARK1_BIT] | role1;
        irq_hit = pass_on && hdr_in[HDR_KIND_BIT]
                  && (hdr_in[HDR_TGT_LSB +: 8] == my_id
                  || hdr_in[HDR_TGT_LSB +: 8] == BROADCAST_ID);
        for (int t = 0; t < GP_KINDS; t++) begin
            ev_push[t] = irq_hit
                         && hdr_in[HDR_TYPE_LSB +: 3] == 3'(t);
        end
        ev_reset = irq_hit
                   && hdr_in[HDR_TYPE_LSB +: 3] == IRQ_RESET_REQ;
        ev_rogue = take && rogue;
        ev_own   = take && own;
    end

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (rx_fire && rx_sop) begin
                    next_state = rx_eop ? ST_DECIDE : ST_COLLECT;
                end else if (local_load) begin
                    next_state = ST_SEND;
                end
            end
            ST_COLLECT: begin
                if (rx_fire && rx_eop) begin
                    next_state = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                next_state = pass_on ? ST_SEND : ST_IDLE;
            end
            ST_SEND: begin
                if (!tx_busy && !tx_valid && !wr_busy) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_IDLE;
            rx_ready <= 1'b0;
        end else begin
            state    <= next_state;
            rx_ready <= next_state == ST_IDLE || next_state == ST_COLLECT;
        end
    end

    // Packet buffer: whole copy held until its error status is known
    always_ff @(posedge pclk) begin
        if (rx_fire && (state == ST_COLLECT || rx_sop)
            && (state == ST_COLLECT || state == ST_IDLE)) begin
            if (state == ST_IDLE) begin
                pkt_buf[0] <= rx_data;
            end else if (rx_cnt < PKT_MAX_W) begin
                pkt_buf[rx_cnt] <= rx_data;
            end
        end else if (local_load) begin
            pkt_buf[0] <= {1'b1, 2'b00, 4'h0, irq_type, 6'h00,
                           irq_target[TGT_BCAST_BIT] ? BROADCAST_ID
                           : irq_target[7:0], my_id};
            pkt_buf[1] <= irq_data;
        end else if (state == ST_DECIDE) begin
            pkt_buf[0] <= hdr_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt      <= 5'h00;
            rx_bad      <= 1'b0;
            pkt_len     <= 5'h00;
            fwd         <= 1'b0;
            apply_mem   <= 1'b0;
            second_copy <= 1'b0;
            first_ok    <= 1'b0;
        end else begin
            if (state == ST_IDLE && rx_fire && rx_sop) begin
                rx_cnt <= 5'h01;
                rx_bad <= rx_eop & rx_err;
            end else if (state == ST_COLLECT && rx_fire) begin
                if (rx_cnt < PKT_MAX_W) begin
                    rx_cnt <= rx_cnt + 5'h01;
                end
                rx_bad <= rx_bad | (rx_eop & rx_err)
                          | (rx_cnt == PKT_MAX_W);
            end
            if (local_load) begin
                pkt_len   <= IRQ_PKT_WORDS;
                fwd       <= 1'b1;
                apply_mem <= 1'b0;
            end else if (state == ST_DECIDE) begin
                pkt_len   <= rx_cnt;
                fwd       <= pass_on;
                apply_mem <= pass_on && !hdr_in[HDR_KIND_BIT];
                if (red_mode) begin
                    second_copy <= !second_copy;
                    if (!second_copy) begin
                        first_ok <= take;
                    end
                end else begin
                    second_copy <= 1'b0;
                end
            end
        end
    end

    // Transmit: one or two passes of the held packet
    logic [1:0] passes;
    assign passes  = red_mode ? 2'd2 : 2'd1;
    assign tx_busy = fwd && tx_pass < passes;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid <= 1'b0;
            tx_sop   <= 1'b0;
            tx_eop   <= 1'b0;
            tx_data  <= 32'h0000_0000;
            tx_idx   <= 5'h00;
            tx_pass  <= 2'd0;
        end else if (state != ST_SEND) begin
            tx_idx  <= 5'h00;
            tx_pass <= 2'd0;
            if (tx_ready) begin
                tx_valid <= 1'b0;
            end
        end else if (!tx_valid || tx_ready) begin
            if (tx_busy && link_ok) begin
                tx_valid <= 1'b1;
                tx_sop   <= tx_idx == 5'h00;
                tx_eop   <= tx_idx == pkt_len - 5'h01;
                tx_data  <= pkt_buf[tx_idx];
                if (tx_idx == pkt_len - 5'h01) begin
                    tx_idx  <= 5'h00;
                    tx_pass <= tx_pass + 2'd1;
                end else begin
                    tx_idx <= tx_idx + 5'h01;
                end
            end else begin
                tx_valid <= 1'b0;
            end
        end
    end

    // Local memory update runs beside the forward transmit
    assign wr_busy = apply_mem && wr_idx < pkt_len;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we   <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_data <= 32'h0000_0000;
            wr_idx   <= DATA_FIRST_WORD;
        end else if (state == ST_SEND && wr_busy) begin
            mem_we   <= 1'b1;
            mem_addr <= pkt_buf[1]
                        + {25'h0, wr_idx - DATA_FIRST_WORD, 2'b00};
            mem_data <= pkt_buf[wr_idx];
            wr_idx   <= wr_idx + 5'h01;
        end else begin
            mem_we <= 1'b0;
            if (state != ST_SEND) begin
                wr_idx <= DATA_FIRST_WORD;
            end
        end
    end

    // Sender and payload queues, one pair of entries per slot
    logic [7:0]  fifo_head_id   [GP_KINDS];
    logic [31:0] fifo_hold_data [GP_KINDS];
    logic [6:0]  fifo_count     [GP_KINDS];

    generate
        for (g = 0; g < GP_KINDS; g++) begin : g_fifo
            logic [39:0]        pair_mem [2**FIFO_AW];
            logic [FIFO_AW-1:0] wr_ptr;
            logic [FIFO_AW-1:0] rd_ptr;
            logic               push;
            logic               pop;

            // One slot holds both words so the pair cannot drift apart
            assign push = ev_push[g] && state == ST_DECIDE
                          && fifo_count[g] != FIFO_DEPTH;
            assign pop  = apb_rd_cap && fifo_addr(paddr, g, 1'b0)
                          && fifo_count[g] != 7'h00;
            assign fifo_head_id[g] = pair_mem[rd_ptr][39:32];

            always_ff @(posedge pclk) begin
                if (push) begin
                    pair_mem[wr_ptr] <= {hdr_in[HDR_ORG_LSB +: 8],
                                         pkt_buf[1]};
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    wr_ptr            <= '0;
                    rd_ptr            <= '0;
                    fifo_count[g]     <= 7'h00;
                    fifo_hold_data[g] <= 32'h0000_0000;
                end else begin
                    if (push) begin
                        wr_ptr <= wr_ptr + 7'h01;
                    end
                    if (pop) begin
                        rd_ptr            <= rd_ptr + 7'h01;
                        fifo_hold_data[g] <= pair_mem[rd_ptr][31:0];
                    end
                    fifo_count[g] <= fifo_count[g] + 7'(push) - 7'(pop);
                end
            end
        end
    endgenerate

    // Register writes and sticky status
    logic [ST_W-1:0] st_set;
    assign st_set = (state == ST_DECIDE)
                    ? {ev_own, ev_rogue, ev_reset, ev_push} : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_target           <= 9'h000;
            irq_type             <= 3'h0;
            irq_data             <= 32'h0000_0000;
            send_pending         <= 1'b0;
            local_irq_status     <= ST_RST;
            local_irq_enable     <= EN_RST;
            host_irq_ctrl_status <= 1'b0;
            host_irq             <= 1'b0;
        end else begin
            if (apb_wr && paddr == REG_IRQ_TARGET) begin
                irq_target <= pwdata[8:0];
            end
            if (apb_wr && paddr == REG_IRQ_DATA) begin
                irq_data <= pwdata;
            end
            // Writing the type launches the packet
            if (apb_wr && paddr == REG_IRQ_TYPE) begin
                irq_type     <= pwdata[2:0];
                send_pending <= 1'b1;
            end else if (local_load) begin
                send_pending <= 1'b0;
            end
            if (apb_wr && paddr == REG_LOCAL_EN) begin
                local_irq_enable <= pwdata[ST_W-1:0];
            end
            if (apb_wr && paddr == REG_HOST_CTRL) begin
                host_irq_ctrl_status <= pwdata[HOST_EN_BIT];
            end
            // Write one to clear; a new event in the same cycle survives
            if (apb_wr && paddr == REG_LOCAL_STAT) begin
                local_irq_status <= (local_irq_status & ~pwdata[ST_W-1:0])
                                    | st_set;
            end else begin
                local_irq_status <= local_irq_status | st_set;
            end
            host_irq <= host_irq_ctrl_status
                        && |(local_irq_status & local_irq_enable);
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped  = 1'b1;
        unique case (paddr)
            REG_IRQ_TARGET: rd_word = {23'h0, irq_target};
            REG_IRQ_TYPE:   rd_word = {28'h0, send_pending, irq_type};
            REG_IRQ_DATA:   rd_word = irq_data;
            REG_LOCAL_STAT: rd_word = {25'h0, local_irq_status};
            REG_LOCAL_EN:   rd_word = {25'h0, local_irq_enable};
            REG_HOST_CTRL:  rd_word = {30'h0, host_irq, host_irq_ctrl_status};
            REG_NODE_STAT:  rd_word = {14'h0, pins[17:16], my_id, opts};
            default: begin
                mapped = 1'b0;
                for (int t = 0; t < GP_KINDS; t++) begin
                    if (fifo_addr(paddr, t, 1'b0)) begin
                        mapped  = 1'b1;
                        rd_word = {fifo_count[t] != 7'h00, 8'h00,
                                   fifo_count[t], 8'h00, fifo_head_id[t]};
                    end else if (fifo_addr(paddr, t, 1'b1)) begin
                        mapped  = 1'b1;
                        rd_word = fifo_hold_data[t];
                    end
                end
            end
        endcase
    end

    // APB answer: one wait state, then pready for a single cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_cap;
            pslverr <= apb_cap & ~mapped;
            if (apb_rd_cap) begin
                prdata <= rd_word;
            end
        end
    end

endmodule

// *** rnirr_pkg.sv ***
// Constants and types shared by the ring node packet logic
package rnirr_pkg;

    // Register byte offsets on the APB slave
    localparam logic [11:0] REG_IRQ_TARGET  = 12'h000;
    localparam logic [11:0] REG_IRQ_TYPE    = 12'h004;
    localparam logic [11:0] REG_IRQ_DATA    = 12'h008;
    localparam logic [11:0] REG_LOCAL_STAT  = 12'h00C;
    localparam logic [11:0] REG_LOCAL_EN    = 12'h010;
    localparam logic [11:0] REG_HOST_CTRL   = 12'h014;
    localparam logic [11:0] REG_NODE_STAT   = 12'h018;
    localparam logic [11:0] REG_FIFO_BASE   = 12'h020;
    localparam logic [11:0] REG_FIFO_STRIDE = 12'h008;
    localparam logic [11:0] REG_FIFO_DATA   = 12'h004;

    // Packet header word layout
    localparam int HDR_KIND_BIT  = 31;
    localparam int HDR_MARK0_BIT = 30;
    localparam int HDR_MARK1_BIT = 29;
    localparam int HDR_LEN_LSB   = 25;
    localparam int HDR_TYPE_LSB  = 22;
    localparam int HDR_TGT_LSB   = 8;
    localparam int HDR_ORG_LSB   = 0;
    localparam int TGT_BCAST_BIT = 8;

    localparam logic [7:0] BROADCAST_ID  = 8'hFF;
    localparam logic [2:0] IRQ_RESET_REQ = 3'h4;

    // Packet and queue sizes
    localparam int         GP_KINDS        = 4;
    localparam int         FIFO_AW         = 7;
    localparam logic [6:0] FIFO_DEPTH      = 7'h7F;
    localparam int         PKT_MAX         = 18;
    localparam logic [4:0] PKT_MAX_W       = 5'h12;
    localparam logic [4:0] IRQ_PKT_WORDS   = 5'h02;
    localparam logic [4:0] DATA_PKT_EXTRA  = 5'h03;
    localparam logic [4:0] DATA_FIRST_WORD = 5'h02;

    // Local interrupt status bits
    localparam int         ST_GP_LSB = 0;
    localparam int         ST_RESET  = 4;
    localparam int         ST_ROGUE  = 5;
    localparam int         ST_OWN    = 6;
    localparam int         ST_W      = 7;
    localparam logic [6:0] ST_RST    = 7'h00;
    localparam logic [6:0] EN_RST    = 7'h00;
    localparam int         HOST_EN_BIT = 0;

    // Option switch positions (bit 0 is position 1)
    localparam int OPT_REDUNDANT = 0;
    localparam int OPT_ROGUE0    = 4;
    localparam int OPT_ROGUE1    = 5;

    localparam int SYNC_W = 18;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_DECIDE,
        ST_SEND
    } rnirr_state_t;

endpackage

// *** rnirr_node_props.sv ***
// Port checker for the ring node
`timescale 1ns/1ps
module rnirr_node_props (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    // Ring
    input wire logic        signal_detect,
    input wire logic        tx_valid,
    input wire logic        tx_sop,
    input wire logic        tx_ready,
    input wire logic [31:0] tx_data,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_next_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("long ready");
    setup_quiet_a: assert property (psel && !penable |-> !pready)
        else $error("early ready");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("lone error");
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_data)) else $error("word dropped");
    tx_start_a: assert property ($rose(tx_valid) |-> tx_sop)
        else $error("no start");
    link_quiet_a: assert property (
        (!signal_detect) [*5] ##0 !tx_valid |=> !tx_valid)
        else $error("sent with no link");
    mem_step_a: assert property (
        mem_we ##1 mem_we |-> mem_addr == $past(mem_addr) + 32'h4)
        else $error("bad word offset");
endmodule
bind rnirr_node rnirr_node_props rnirr_node_props_i (.*);

// *** rnirr_ring_model.sv ***
// Neighbour nodes: upstream sender and stalling downstream
`timescale 1ns/1ps
module rnirr_ring_model (
    // Clock
    input wire logic        pclk,
    // Upstream beats
    output logic            rx_valid = 1'b0,
    output logic            rx_sop = 1'b0,
    output logic            rx_eop = 1'b0,
    output logic     [31:0] rx_data = 32'h0,
    output logic            rx_err = 1'b0,
    input wire logic        rx_ready,
    // Downstream accept
    input wire logic        tx_valid,
    input wire logic [31:0] tx_data,
    output logic            tx_ready = 1'b0
);
    logic [31:0] got[$];
    int          sd = 32'h699ADEB4;
    // Random stalls force the node to hold words
    always @(posedge pclk) begin
        tx_ready <= $random(sd) % 3 != 0;
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
    end
    task automatic send(input logic [31:0] w[$], input logic bad);
        for (int i = 0; i < w.size(); i++) begin
            rx_valid <= 1'b1;
            rx_sop   <= i == 0;
            rx_eop   <= i == w.size() - 1;
            rx_err   <= bad;
            rx_data  <= w[i];
            @(posedge pclk);
            for (int n = 0; n < 99 && !rx_ready; n++) @(posedge pclk);
        end
        rx_valid <= 1'b0;
        // Released line must not keep showing the last word
        rx_data  <= ~rx_data;
        @(posedge pclk);
    endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the ring node
`timescale 1ns/1ps
module testbench import rnirr_pkg::*;;
    logic        pclk, pready, pslverr, rx_valid, rx_sop, rx_eop, rx_err;
    logic        rx_ready, tx_valid, tx_sop, tx_eop, tx_ready, mem_we;
    logic        host_irq, se;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, signal_detect = 1'b1, rx_locked = 1'b1;
    logic [11:0] paddr = 12'h0, fa;
    logic [31:0] pwdata = 32'h0, prdata, rx_data, tx_data, mem_addr;
    logic [31:0] mem_data, rd, pay, hd, exp[$], mexp[$], memq[$];
    logic [7:0]  option_switch_bank = 8'h00, node_id_switch = 8'h05;
    int          err_total, checks_done, seed = 32'h699ADEB4;

    rnirr_node rnirr_node_i (.*);
    rnirr_ring_model rnirr_ring_model_i (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (mem_we) begin
            memq.push_back(mem_addr);
            memq.push_back(mem_data);
        end
    end
    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (int n = 0; n < 9 && !pready; n++) @(posedge pclk);
        if (!pready) err_total++;
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wt(input int k);
        for (int n = 0; n < 300 && rnirr_ring_model_i.got.size() < k; n++)
            @(posedge pclk);
        if (rnirr_ring_model_i.got.size() < k) err_total++;
    endtask
    function automatic logic [31:0] irq(input int t, input logic [7:0] g,
                                        input logic [7:0] o);
        return 32'h8000_0000 | t << HDR_TYPE_LSB | g << HDR_TGT_LSB | o;
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        signal_detect <= 1'b0;
        pay = $random(seed);
        apb(1'b1, REG_IRQ_TARGET, 32'h9);
        apb(1'b1, REG_IRQ_DATA, pay);
        apb(1'b1, REG_IRQ_TYPE, 32'h2);
        repeat (8) @(posedge pclk);
        chk(rnirr_ring_model_i.got.size(), 0);
        signal_detect <= 1'b1;
        exp = '{irq(2, 8'h09, 8'h05), pay};
        wt(2);
        $display("test link hold done");
        for (int t = 0; t < 4; t++) begin
            pay = $random(seed);
            hd = irq(t, t == 3 ? BROADCAST_ID : 8'h05, 8'h03);
            rnirr_ring_model_i.send('{hd, pay}, 1'b0);
            exp.push_back(hd);
            exp.push_back(pay);
            wt(exp.size());
            fa = REG_FIFO_BASE + REG_FIFO_STRIDE * t;
            apb(1'b0, fa, 32'h0);
            chk(rd, 32'h8001_0003);
            apb(1'b0, fa + REG_FIFO_DATA, 32'h0);
            chk(rd, pay);
        end
        hd = irq(0, 8'h05, 8'h03);
        repeat (128) begin
            rnirr_ring_model_i.send('{hd, pay}, 1'b0);
            exp = {exp, hd, pay};
        end
        apb(1'b0, REG_FIFO_BASE, 32'h0);
        chk(rd, 32'h807F_0003);
        apb(1'b0, REG_FIFO_BASE + REG_FIFO_DATA, 32'h0);
        chk(rd, pay);
        $display("test queues done");
        apb(1'b1, REG_LOCAL_STAT, 32'h7F);
        apb(1'b1, REG_LOCAL_EN, 32'h10);
        hd = irq(4, 8'h05, 8'h03);
        rnirr_ring_model_i.send('{hd, pay}, 1'b0);
        exp.push_back(hd);
        exp.push_back(pay);
        wt(exp.size());
        apb(1'b0, REG_LOCAL_STAT, 32'h0);
        chk(rd, 32'h10);
        chk(host_irq, 1'b0);
        apb(1'b1, REG_HOST_CTRL, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({se, rd[30:0]}, 32'h8000_0000);
        chk(host_irq, 1'b1);
        apb(1'b1, REG_LOCAL_STAT, 32'h10);
        apb(1'b0, REG_LOCAL_STAT, 32'h0);
        chk(host_irq, 1'b0);
        $display("test reset request done");
        rnirr_ring_model_i.send('{irq(0, 8'h09, 8'h05), pay}, 1'b0);
        option_switch_bank <= 8'h30;
        repeat (6) @(posedge pclk);
        for (int m = 0; m < 2; m++)
            rnirr_ring_model_i.send('{32'h0200_0003 | m << 29, 32'h200,
                                      pay, ~pay}, 1'b0);
        exp = {exp, 32'h6200_0003, 32'h200, pay, ~pay};
        mexp = {32'h200, pay, 32'h204, ~pay};
        apb(1'b0, REG_LOCAL_STAT, 32'h0);
        chk(rd, 32'h60);
        $display("test rogue done");
        option_switch_bank <= 8'h01;
        repeat (6) @(posedge pclk);
        // Case 0 bad then good, 1 good twice, 2 both bad
        for (int c = 0; c < 3; c++) begin
            pay = $random(seed);
            hd = 32'h100 + 32'h10 * c;
            rnirr_ring_model_i.send('{32'h0200_0003, hd, pay, ~pay}, c != 1);
            rnirr_ring_model_i.send('{32'h0200_0003, hd, pay, ~pay}, c == 2);
            if (c < 2) begin
                mexp = {mexp, hd, pay, hd + 32'h4, ~pay};
                repeat (2) exp = {exp, 32'h0200_0003, hd, pay, ~pay};
            end
        end
        wt(exp.size());
        repeat (20) @(posedge pclk);
        $display("test redundant done");
        chk(rnirr_ring_model_i.got.size(), exp.size());
        foreach (exp[i]) chk(rnirr_ring_model_i.got[i], exp[i]);
        chk(memq.size(), mexp.size());
        foreach (mexp[i]) chk(memq[i], mexp[i]);
        close_out;
    end
endmodule
